// *** shared/tcr_pkg.sv ***
package tcr_pkg;
   // ----------------------------------------------------------------
   // Channel group shape
   // ----------------------------------------------------------------
   localparam int NCH = 4;
   localparam int DW = 8;
   localparam int X2_LANES = 2;
   localparam logic [DW-1:0] WORD_RST = 8'h00;
   localparam logic PHASE_RST = 1'b0;

   // ----------------------------------------------------------------
   // Operating choices
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      TX_ONLY,
      RX_ONLY,
      TX_RX
   } tcr_mode_type;

   typedef enum logic [1:0] {
      BOND_X1,
      BOND_X2,
      BOND_X4
   } tcr_bond_type;

   function automatic logic tcr_bonded(input tcr_bond_type b,
         input tcr_mode_type m, input int ch);
      tcr_bonded = (m != RX_ONLY) &&
         ((b == BOND_X4) || ((b == BOND_X2) && (ch < X2_LANES)));
   endfunction : tcr_bonded
endpackage : tcr_pkg

// *** shared/tcr_if.sv ***
interface tcr_if;
   import tcr_pkg::*;
   // Clock ticks exported to the fabric
   logic [NCH-1:0] txClkOut;
   logic [NCH-1:0] rxClkOut;
   logic coreClkOut;
   // Channel data in both directions
   logic [NCH-1:0][DW-1:0] txData;
   logic [NCH-1:0][DW-1:0] rxData;

   modport dev(output txClkOut, output rxClkOut, output coreClkOut,
      input txData, output rxData);
   modport fab(input txClkOut, input rxClkOut, input coreClkOut,
      output txData, input rxData);
endinterface : tcr_if

// *** rtl/tcr_fabric_end.sv ***
module tcr_fabric_end
   import tcr_pkg::*;
(
   // Clock, reset, enable
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic clkEn,
   // Configuration, same as the device end
   input wire tcr_mode_type mode,
   input wire tcr_bond_type bond,
   input wire logic rateMatch,
   // User side
   input wire logic [NCH-1:0][DW-1:0] txWordIn,
   output logic [NCH-1:0][DW-1:0] rxWordOut,
   output logic [NCH-1:0] txLaunch,
   output logic [NCH-1:0] rxCapture,
   // Link
   tcr_if.fab link
);
   typedef struct packed {
      logic [NCH-1:0][DW-1:0] tx;
      logic [NCH-1:0][DW-1:0] rx;
   } tcr_fab_state_type;

   tcr_fab_state_type s_q, s_d;
   logic rmEff;

   // ----------------------------------------------------------------
   // Clock choice per channel
   // ----------------------------------------------------------------
   assign rmEff = rateMatch && (mode == TX_RX);

   always_comb begin
      for (int c = 0; c < NCH; c++) begin
         if (tcr_bonded(bond, mode, c)) begin
            txLaunch[c] = clkEn && link.coreClkOut;
            rxCapture[c] = clkEn && (rmEff ? link.coreClkOut
               : link.rxClkOut[c]);
         end else begin
            txLaunch[c] = clkEn && link.txClkOut[c];
            rxCapture[c] = clkEn && (rmEff ? link.txClkOut[c]
               : link.rxClkOut[c]);
         end
         if (mode == RX_ONLY) begin
            txLaunch[c] = 1'b0;
         end
         if (mode == TX_ONLY) begin
            rxCapture[c] = 1'b0;
         end
      end
   end

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   always_comb begin
      s_d = s_q;
      for (int c = 0; c < NCH; c++) begin
         if (txLaunch[c]) begin
            s_d.tx[c] = txWordIn[c];
         end
         if (rxCapture[c]) begin
            s_d.rx[c] = link.rxData[c];
         end
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         s_q <= '0;
      end else if (clkEn) begin
         s_q <= s_d;
      end
   end

   assign link.txData = s_q.tx;
   assign rxWordOut = s_q.rx;
endmodule : tcr_fabric_end

// *** rtl/tcr_device_end.sv ***
// Behaviour
// - Non-bonded TX takes fast and slow from one PLL
// - Fast serial clock drives the serializer
// - Slow clock drives encoder, serializer read, FIFO read
// - Byte serializer halves the TX FIFO read clock
// - Export TX slow clock; fabric sends with it
// - RX-only never uses the rate match FIFO
// - Recovered slow clock drives RX PCS; fast deserializes
// - Byte deserializer halves recovered clock for FIFO
// - Export recovered clock; fabric captures with it
// - TX-RX allows rate match; TX clocking unchanged
// - Rate match: recovered clock drives aligner, FIFO write
// - Rate match: TX slow clock drives remaining RX PCS
// - Rate match plus deserializer halves TX clock
// - Rate match: fabric uses TX clock both ways
// - Bonded channels share one slow clock and FIFO control
// - Fast clock per channel; shared from adjacent PLL
// - X2 uses channels 0,1; 2,3 stay independent
// - Shared clock drives bonded TX PCS, exported
// - Bonded byte serializer halves the shared clock
// - No bonding in receive-only operation
// - Bonded rate match splits recovered and shared clocks
// - Bonded rate match plus deserializer halves shared; fabric uses it
module tcr_device_end
   import tcr_pkg::*;
(
   // Clock, reset, enable
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic clkEn,
   // Configuration
   input wire tcr_mode_type mode,
   input wire tcr_bond_type bond,
   input wire logic rateMatch,
   input wire logic byteSer,
   input wire logic [NCH-1:0] pllSel,
   input wire logic bondPllSel,
   output logic cfgError,
   // Adjacent PLL ticks, A and B
   input wire logic pllFastA,
   input wire logic pllFastB,
   input wire logic pllSlowA,
   input wire logic pllSlowB,
   // Recovered ticks per channel
   input wire logic [NCH-1:0] recFast,
   input wire logic [NCH-1:0] recSlow,
   // Transmit block enables
   output logic [NCH-1:0] serTick,
   output logic [NCH-1:0] encTick,
   output logic [NCH-1:0] bserRdTick,
   output logic [NCH-1:0] txFifoRdTick,
   // Receive block enables
   output logic [NCH-1:0] deserTick,
   output logic [NCH-1:0] alignTick,
   output logic [NCH-1:0] rmWrTick,
   output logic [NCH-1:0] rmRdTick,
   output logic [NCH-1:0] decTick,
   output logic [NCH-1:0] bdesWrTick,
   output logic [NCH-1:0] orderTick,
   output logic [NCH-1:0] rxFifoWrTick,
   // Datapath words
   input wire logic [NCH-1:0][DW-1:0] rxWordIn,
   output logic [NCH-1:0][DW-1:0] txWordOut,
   // Link
   tcr_if.dev link
);
   typedef struct packed {
      logic [NCH-1:0] txPhase;
      logic [NCH-1:0] rxPhase;
      logic bondPhase;
      logic [NCH-1:0][DW-1:0] txWord;
      logic [NCH-1:0][DW-1:0] rxWord;
   } tcr_dev_state_type;

   tcr_dev_state_type s_q, s_d;
   logic txEn, rxEn, rmEff, sharedSlow, anyBond;
   logic [NCH-1:0] bonded, chSlow, txSlow, txHalf, recHalf, pcsRx;

   // ----------------------------------------------------------------
   // Mode decode
   // ----------------------------------------------------------------
   assign txEn = clkEn && (mode != RX_ONLY);
   assign rxEn = clkEn && (mode != TX_ONLY);
   assign rmEff = rateMatch && (mode == TX_RX);
   assign cfgError = (mode == RX_ONLY) &&
      (rateMatch || (bond != BOND_X1));
   assign sharedSlow = bondPllSel ? pllSlowB : pllSlowA;
   assign anyBond = |bonded;

   // ----------------------------------------------------------------
   // Clock routing per channel
   // ----------------------------------------------------------------
   always_comb begin
      for (int c = 0; c < NCH; c++) begin
         bonded[c] = tcr_bonded(bond, mode, c);
         chSlow[c] = pllSel[c] ? pllSlowB : pllSlowA;
         txSlow[c] = bonded[c] ? sharedSlow : chSlow[c];
         txHalf[c] = txSlow[c] &&
            (bonded[c] ? s_q.bondPhase : s_q.txPhase[c]);
         recHalf[c] = recSlow[c] && s_q.rxPhase[c];
         pcsRx[c] = rmEff ? txSlow[c] : recSlow[c];

         serTick[c] = txEn && (pllSel[c] ? pllFastB : pllFastA);
         encTick[c] = txEn && txSlow[c];
         bserRdTick[c] = txEn && txSlow[c];
         txFifoRdTick[c] = txEn &&
            (byteSer ? txHalf[c] : txSlow[c]);

         deserTick[c] = rxEn && recFast[c];
         alignTick[c] = rxEn && recSlow[c];
         rmWrTick[c] = rxEn && rmEff && recSlow[c];
         rmRdTick[c] = rxEn && rmEff && txSlow[c];
         decTick[c] = rxEn && pcsRx[c];
         bdesWrTick[c] = rxEn && pcsRx[c];
         orderTick[c] = rxEn && pcsRx[c];
         if (!byteSer) begin
            rxFifoWrTick[c] = rxEn && pcsRx[c];
         end else if (rmEff) begin
            rxFifoWrTick[c] = rxEn && txHalf[c];
         end else begin
            rxFifoWrTick[c] = rxEn && recHalf[c];
         end

         link.txClkOut[c] = (mode != RX_ONLY) && !bonded[c] &&
            chSlow[c];
         link.rxClkOut[c] = (mode != TX_ONLY) && recSlow[c];
      end
   end

   assign link.coreClkOut = anyBond && sharedSlow;

   // ----------------------------------------------------------------
   // Dividers and FIFO-side words
   // ----------------------------------------------------------------
   always_comb begin
      s_d = s_q;
      if (sharedSlow) begin
         s_d.bondPhase = !s_q.bondPhase;
      end
      for (int c = 0; c < NCH; c++) begin
         if (chSlow[c]) begin
            s_d.txPhase[c] = !s_q.txPhase[c];
         end
         if (recSlow[c]) begin
            s_d.rxPhase[c] = !s_q.rxPhase[c];
         end
         if (txFifoRdTick[c]) begin
            s_d.txWord[c] = link.txData[c];
         end
         if (rxFifoWrTick[c]) begin
            s_d.rxWord[c] = rxWordIn[c];
         end
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         s_q <= '0;
      end else if (clkEn) begin
         s_q <= s_d;
      end
   end

   assign txWordOut = s_q.txWord;
   assign link.rxData = s_q.rxWord;
endmodule : tcr_device_end

// *** dv/tcr_clk_sva.sv ***
module tcr_clk_sva
   import tcr_pkg::*;
(
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rst_n,
   // Configuration and sources
   input wire logic clkEn,
   input wire tcr_mode_type mode,
   input wire tcr_bond_type bond,
   input wire logic rateMatch,
   input wire logic [NCH-1:0] pllSel,
   input wire logic bondPllSel,
   input wire logic pllSlowA,
   input wire logic pllSlowB,
   input wire logic [NCH-1:0] recSlow,
   // Link
   input wire logic [NCH-1:0] txClkOut,
   input wire logic [NCH-1:0] rxClkOut,
   input wire logic coreClkOut,
   input wire logic [NCH-1:0][DW-1:0] txData,
   input wire logic [NCH-1:0][DW-1:0] rxData
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [NCH-1:0] bnd;
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!rst_n);
   for (genvar i = 0; i < NCH; i++) begin : g_ch
      assign bnd[i] = (mode != RX_ONLY) && ((bond == BOND_X4) ||
         ((bond == BOND_X2) && (i < X2_LANES)));
      a_tx_clk_export: assert property (
         clkEn && mode != RX_ONLY && !bnd[i] |->
         txClkOut[i] == (pllSel[i] ? pllSlowB : pllSlowA))
         else $error("tx clock wrong");
      a_rx_clk_export: assert property (
         clkEn && mode != TX_ONLY && !(mode == TX_RX && rateMatch) |->
         rxClkOut[i] == recSlow[i]) else $error("rx clock wrong");
      a_bonded_tx_quiet: assert property (
         bnd[i] |-> !txClkOut[i]) else $error("bonded tx clock");
      a_rxonly_no_tx: assert property (
         mode == RX_ONLY |-> !txClkOut[i]) else $error("tx in rx only");
      a_txonly_no_rx: assert property (
         mode == TX_ONLY |-> !rxClkOut[i]) else $error("rx in tx only");
      a_tx_word_launch: assert property (
         !$stable(txData[i]) |-> $past(txClkOut[i] || coreClkOut))
         else $error("tx word off tick");
      a_rx_word_write: assert property (
         !$stable(rxData[i]) |->
         $past(rxClkOut[i] || txClkOut[i] || coreClkOut))
         else $error("rx word off tick");
   end
   a_core_shared: assert property (
      clkEn && bond != BOND_X1 && mode != RX_ONLY |->
      coreClkOut == (bondPllSel ? pllSlowB : pllSlowA))
      else $error("core clock wrong");
endmodule : tcr_clk_sva

// *** dv/transceiver_datapath_clock_routing_bench.sv ***
module transceiver_datapath_clock_routing_bench import tcr_pkg::*;;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_sys, rst_n, clkEn, rateMatch, byteSer, bondPllSel, cfgError;
   logic pllFastA, pllFastB, pllSlowA, pllSlowB;
   tcr_mode_type mode;
   tcr_bond_type bond;
   logic [NCH-1:0] pllSel, recFast, recSlow, serTick, encTick, bserRdTick;
   logic [NCH-1:0] txFifoRdTick, deserTick, alignTick, rmWrTick, rmRdTick;
   logic [NCH-1:0] decTick, bdesWrTick, orderTick, rxFifoWrTick;
   logic [NCH-1:0] txLaunch, rxCapture;
   logic [NCH-1:0][DW-1:0] rxWordIn, txWordOut, txWordIn, rxWordOut;
   int errTotal = 0;
   int samplesChecked = 0;
   tcr_if link();
   tcr_device_end u_tcr_device_end (.clk_sys, .rst_n, .clkEn, .mode, .bond,
      .rateMatch, .byteSer, .pllSel, .bondPllSel, .cfgError, .pllFastA,
      .pllFastB, .pllSlowA, .pllSlowB, .recFast, .recSlow, .serTick,
      .encTick, .bserRdTick, .txFifoRdTick, .deserTick, .alignTick,
      .rmWrTick, .rmRdTick, .decTick, .bdesWrTick, .orderTick,
      .rxFifoWrTick, .rxWordIn, .txWordOut, .link);
   tcr_fabric_end u_tcr_fabric_end (.clk_sys, .rst_n, .clkEn, .mode, .bond,
      .rateMatch, .txWordIn, .rxWordOut, .txLaunch, .rxCapture, .link);
   tcr_clk_sva u_chk (.clk_sys, .rst_n, .clkEn, .mode, .bond, .rateMatch,
      .pllSel, .bondPllSel, .pllSlowA, .pllSlowB, .recSlow,
      .txClkOut(link.txClkOut), .rxClkOut(link.rxClkOut),
      .coreClkOut(link.coreClkOut), .txData(link.txData),
      .rxData(link.rxData));
   initial begin
      clk_sys = 1'h0;
      forever #12.5 clk_sys = ~clk_sys;
   end
   task automatic chk(input string n, input logic [31:0] s, e);
      samplesChecked++;
      if (s !== e) begin
         errTotal++;
         $display("mismatch %s expected %h seen %h", n, e, s);
      end
   endtask : chk
   task automatic drv(input logic a, b, input logic [NCH-1:0] r);
      @(posedge clk_sys);
      #1;
      {pllSlowA, pllFastA, pllSlowB, pllFastB} = {a, a, b, b};
      {recSlow, recFast} = {r, r};
      #5;
   endtask : drv
   task automatic en(input logic e);
      @(posedge clk_sys);
      #1;
      clkEn = e;
   endtask : en
   task automatic cfg(input tcr_mode_type m, input tcr_bond_type b,
         input logic rm, bs, bp, input logic [NCH-1:0] ps);
      @(posedge clk_sys);
      #1;
      rst_n = 1'h0;
      {pllSlowA, pllFastA, pllSlowB, pllFastB, recSlow, recFast} = 12'h000;
      mode = m;
      bond = b;
      {rateMatch, byteSer, bondPllSel, pllSel} = {rm, bs, bp, ps};
      @(posedge clk_sys);
      #1;
      rst_n = 1'h1;
   endtask : cfg
   task automatic results;
      $display("checks %0d mismatches %0d", samplesChecked, errTotal);
      if (errTotal == 0 && samplesChecked > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : results
   initial begin
      {rst_n, clkEn, rateMatch, byteSer, bondPllSel} = 5'h08;
      mode = TX_ONLY;
      bond = BOND_X1;
      {pllSel, recSlow, recFast} = 12'h000;
      {pllSlowA, pllFastA, pllSlowB, pllFastB} = 4'h0;
      rxWordIn = 32'h0F1E2D3C;
      txWordIn = 32'h44332211;
      repeat (5) @(posedge clk_sys);
      #1 rst_n = 1'h1;
      cfg(TX_ONLY, BOND_X1, 1'h0, 1'h1, 1'h0, 4'h2);
      drv(1'h1, 1'h0, 4'h0);
      chk("ser", serTick, 4'hD);
      chk("enc", encTick, 4'hD);
      chk("txrd", txFifoRdTick, 4'h0);
      chk("txclk", link.txClkOut, 4'hD);
      chk("bserrd", bserRdTick, 4'hD);
      chk("launch", txLaunch, 4'hD);
      chk("cfgerr", cfgError, 1'h0);
      drv(1'h1, 1'h0, 4'h0);
      chk("txrd", txFifoRdTick, 4'hD);
      drv(1'h0, 1'h0, 4'h0);
      chk("txword", txWordOut, 32'h44330011);
      en(1'h0);
      drv(1'h1, 1'h0, 4'h0);
      chk("enc", encTick, 4'h0);
      chk("txword", txWordOut, 32'h44330011);
      en(1'h1);
      $display("test tx_only done");
      cfg(RX_ONLY, BOND_X4, 1'h1, 1'h0, 1'h0, 4'h0);
      chk("cfgerr", cfgError, 1'h1);
      drv(1'h0, 1'h0, 4'hF);
      chk("align", alignTick, 4'hF);
      chk("deser", deserTick, 4'hF);
      chk("rxwr", rxFifoWrTick, 4'hF);
      chk("rmwr", rmWrTick, 4'h0);
      chk("rxclk", link.rxClkOut, 4'hF);
      chk("txclk", link.txClkOut, 4'h0);
      drv(1'h0, 1'h0, 4'hF);
      drv(1'h0, 1'h0, 4'h0);
      chk("rxword", rxWordOut, 32'h0F1E2D3C);
      $display("test rx_only done");
      cfg(TX_RX, BOND_X1, 1'h1, 1'h1, 1'h0, 4'h0);
      drv(1'h1, 1'h0, 4'h0);
      chk("dec", decTick, 4'hF);
      chk("rmrd", rmRdTick, 4'hF);
      chk("align", alignTick, 4'h0);
      chk("rxwr", rxFifoWrTick, 4'h0);
      chk("order", orderTick, 4'hF);
      chk("bdeswr", bdesWrTick, 4'hF);
      chk("capture", rxCapture, 4'hF);
      drv(1'h0, 1'h0, 4'hF);
      chk("rmwr", rmWrTick, 4'hF);
      chk("dec", decTick, 4'h0);
      drv(1'h1, 1'h0, 4'h0);
      chk("rxwr", rxFifoWrTick, 4'hF);
      drv(1'h1, 1'h0, 4'h0);
      drv(1'h0, 1'h0, 4'h0);
      chk("rxword", rxWordOut, 32'h0F1E2D3C);
      $display("test rate_match done");
      cfg(TX_RX, BOND_X2, 1'h1, 1'h1, 1'h1, 4'h0);
      drv(1'h0, 1'h1, 4'h0);
      chk("core", link.coreClkOut, 1'h1);
      chk("enc", encTick, 4'h3);
      chk("txclk", link.txClkOut, 4'h0);
      chk("txrd", txFifoRdTick, 4'h0);
      chk("launch", txLaunch, 4'h3);
      chk("capture", rxCapture, 4'h3);
      drv(1'h1, 1'h1, 4'h0);
      chk("enc", encTick, 4'hF);
      chk("txclk", link.txClkOut, 4'hC);
      chk("txrd", txFifoRdTick, 4'h3);
      chk("rxwr", rxFifoWrTick, 4'h3);
      chk("dec", decTick, 4'hF);
      chk("launch", txLaunch, 4'hF);
      drv(1'h0, 1'h0, 4'h3);
      chk("align", alignTick, 4'h3);
      chk("rmwr", rmWrTick, 4'h3);
      chk("dec", decTick, 4'h0);
      $display("test bonded done");
      cfg(RX_ONLY, BOND_X1, 1'h0, 1'h1, 1'h0, 4'h0);
      chk("cfgerr", cfgError, 1'h0);
      drv(1'h0, 1'h0, 4'hF);
      chk("rxwr", rxFifoWrTick, 4'h0);
      chk("bdeswr", bdesWrTick, 4'hF);
      chk("order", orderTick, 4'hF);
      chk("capture", rxCapture, 4'hF);
      chk("launch", txLaunch, 4'h0);
      drv(1'h0, 1'h0, 4'hF);
      chk("rxwr", rxFifoWrTick, 4'hF);
      $display("test rx_halved done");
      cfg(TX_ONLY, BOND_X4, 1'h0, 1'h0, 1'h0, 4'hF);
      drv(1'h1, 1'h0, 4'h0);
      chk("core", link.coreClkOut, 1'h1);
      chk("ser", serTick, 4'h0);
      chk("enc", encTick, 4'hF);
      chk("bserrd", bserRdTick, 4'hF);
      chk("txrd", txFifoRdTick, 4'hF);
      chk("txclk", link.txClkOut, 4'h0);
      chk("launch", txLaunch, 4'hF);
      chk("capture", rxCapture, 4'h0);
      $display("test bonded_x4 done");
      cfg(TX_RX, BOND_X1, 1'h0, 1'h0, 1'h0, 4'h0);
      drv(1'h1, 1'h0, 4'h5);
      chk("dec", decTick, 4'h5);
      chk("rmrd", rmRdTick, 4'h0);
      chk("enc", encTick, 4'hF);
      chk("rxwr", rxFifoWrTick, 4'h5);
      chk("capture", rxCapture, 4'h5);
      chk("launch", txLaunch, 4'hF);
      $display("test no_rate_match done");
      results();
   end
endmodule : transceiver_datapath_clock_routing_bench
